//--- verilog/rscd_pkg.sv
// package: shared constants and types for the ring symbol check and diagnostics block
package rscd_pkg;

  localparam int DATA_W = 35;
  localparam int CHECK_W = 7;
  localparam int SYM_W = 32;
  localparam int NIB_W = 4;
  localparam int ID_W = 4;

  // diagnostics word field positions
  localparam int DIAG_NODE_ID_LSB = 0;
  localparam int DIAG_MAX_ID_LSB = 4;
  localparam int DIAG_ERR_LSB = 8;
  localparam int DIAG_SYN_LSB = 12;
  localparam int DIAG_SYN_MSB = 18;

  // error status bits
  localparam int ERR_CHECK_BIT = 0;
  localparam int ERR_ABORT_SYM_BIT = 1;
  localparam int ERR_SEQ_BIT = 2;
  localparam int ERR_ADDR_BIT = 3;

  // reset values
  localparam logic [31:0] RX_CAPTURE_RST = 32'h0000_0000;
  localparam logic [3:0] ERR_RST = 4'h0;
  localparam logic [6:0] SYN_RST = 7'h00;

  // nibble select: top bit picks the diagnostics word
  localparam int SEL_DIAG_BIT = 3;

  typedef enum logic [2:0] {
    RSCD_NO_ERROR,
    RSCD_DOUBLE,
    RSCD_SINGLE_CHECK,
    RSCD_SINGLE_DATA,
    RSCD_SINGLE_TOP
  } rscd_class_t;

endpackage : rscd_pkg

//--- verilog/rscd_check_gen.sv
// check field generator over the 35-bit protected word
module rscd_check_gen #(
  parameter int DATA_W = 35
) (
  input wire logic [DATA_W-1:0] data_in,
  output logic [6:0] check_out
);

  // column n (1..35) of the code carries the 6-bit number n in check bits 0..5,
  // so a single data error makes the low syndrome equal to its position number
  logic [5:0] low_check;

  always_comb begin
    low_check = 6'h00;
    for (int n = 1; n <= DATA_W; n++) begin
      if (data_in[n-1]) begin
        low_check = low_check ^ 6'(n);
      end
    end
  end

  // overall parity over all data and check bits 0..5 gives double detection
  assign check_out = {(^data_in) ^ (^low_check), low_check};

endmodule : rscd_check_gen

//--- verilog/rscd_syndrome_class.sv
// syndrome classifier for the modified hamming code
module rscd_syndrome_class (
  input wire logic [6:0] syndrome,
  output rscd_pkg::rscd_class_t err_class,
  output logic [5:0] err_position
);

  logic low_nonzero;
  logic low_onehot;

  assign low_nonzero = |syndrome[5:0];
  assign low_onehot = low_nonzero && ((syndrome[5:0] & (syndrome[5:0] - 6'h01)) == 6'h00);

  always_comb begin
    err_position = 6'h00;
    if (!low_nonzero && !syndrome[6]) begin
      err_class = rscd_pkg::RSCD_NO_ERROR;
    end else if (low_nonzero && !syndrome[6]) begin
      err_class = rscd_pkg::RSCD_DOUBLE;
    end else if (low_onehot) begin
      err_class = rscd_pkg::RSCD_SINGLE_CHECK;
      err_position = syndrome[5:0];
    end else if (low_nonzero) begin
      err_class = rscd_pkg::RSCD_SINGLE_DATA;
      err_position = syndrome[5:0];
    end else begin
      err_class = rscd_pkg::RSCD_SINGLE_TOP;
    end
  end

endmodule : rscd_syndrome_class

//--- verilog/rscd_ring_check.sv
// ring node symbol check, abort logging and nibble diagnostic readout
// Notes on behaviour
// - hold last client receive symbol, read-only
// - nibble select picks symbol or diagnostics nibble
// - seven check bits, double errors detected
// - syndrome is received xor regenerated check field
// - low check bits xor subsets; top is total
// - every downstream symbol gets a correct check field
// - every upstream symbol goes through the checker
// - check field never on client ports
// - abort pin on bad address or sequence
// - aborting symbol still travels on to target
// - only first abort logged until ring reset
// - zero syndrome means no error
// - low bits set, top clear: double error
// - low bits set, top set: single error
// - one low bit set: that check bit wrong
// - several low bits: data bit position number
// - low bits zero, top set: check bit six
// - check error: log and abort pin, no symbol
// - address or sequence aborts without a check error emit an abort symbol downstream
// - generator logs cause, others log abort symbol
module rscd_ring_check #(
  parameter int DATA_W = 35,
  parameter int ID_W = 4
) (
  input wire logic clk_sys,
  input wire logic srst,
  // upstream ring port
  input wire logic up_valid,
  input wire logic [DATA_W-1:0] up_data,
  input wire logic [6:0] up_check,
  input wire logic up_is_abort_sym,
  input wire logic up_seq_error,
  input wire logic [ID_W-1:0] up_target_id,
  // node identity and ring size
  input wire logic [ID_W-1:0] node_id,
  input wire logic [ID_W-1:0] max_id,
  // downstream ring port, fed by node core
  input wire logic dn_valid_in,
  input wire logic [DATA_W-1:0] dn_data_in,
  output logic dn_valid,
  output logic [DATA_W-1:0] dn_data,
  output logic [6:0] dn_check,
  output logic dn_abort_sym,
  // client receive port
  output logic rx_valid,
  output logic [31:0] rx_symbol,
  // diagnostic readout
  input wire logic [3:0] nibble_select,
  output logic [3:0] nibble_out,
  output logic abort_pin,
  output rscd_pkg::rscd_class_t err_class
);

  ////////////////////////////////////////////////////////////////////////////
  // check generation on both ports

  logic [6:0] up_gen_check;
  logic [6:0] regenerated_check_field;
  logic [6:0] dn_gen_check;
  logic [6:0] syndrome_word;
  rscd_pkg::rscd_class_t class_now;
  logic [5:0] err_position;
  logic check_err;
  logic addr_err;
  logic abort_now;
  logic abort_cause_local;

  rscd_check_gen #(.DATA_W(DATA_W)) u_up_gen (
    .data_in(up_data),
    .check_out(up_gen_check)
  );

  // top bit re-taken over the received low check bits, so a lone flipped
  // check bit still shows as a single error instead of a double
  assign regenerated_check_field = {up_gen_check[6] ^ (^up_gen_check[5:0]) ^ (^up_check[5:0]),
                                    up_gen_check[5:0]};

  rscd_check_gen #(.DATA_W(DATA_W)) u_dn_gen (
    .data_in(dn_data_in),
    .check_out(dn_gen_check)
  );

  assign syndrome_word = up_check ^ regenerated_check_field;

  rscd_syndrome_class u_class (
    .syndrome(syndrome_word),
    .err_class(class_now),
    .err_position(err_position)
  );

  assign check_err = up_valid && (syndrome_word != 7'h00);
  assign addr_err = up_valid && (up_target_id > max_id);
  assign abort_cause_local = addr_err || (up_valid && up_seq_error);
  assign abort_now = check_err || abort_cause_local || (up_valid && up_is_abort_sym);

  ////////////////////////////////////////////////////////////////////////////
  // downstream port: forward, attach check field, add abort symbol

  logic dn_valid_reg;
  logic [DATA_W-1:0] dn_data_reg;
  logic [6:0] dn_check_reg;
  logic dn_abort_reg;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      dn_valid_reg <= 1'b0;
      dn_data_reg <= '0;
      dn_check_reg <= 7'h00;
    end else begin
      dn_valid_reg <= dn_valid_in; // core keeps forwarding the faulty symbol
      dn_data_reg <= dn_data_in;
      dn_check_reg <= dn_gen_check;
    end
  end

  // abort symbol only for address or sequence faults; a check fault stays local
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      dn_abort_reg <= 1'b0;
    end else begin
      dn_abort_reg <= abort_cause_local && !check_err;
    end
  end

  assign dn_valid = dn_valid_reg;
  assign dn_data = dn_data_reg;
  assign dn_check = dn_check_reg;
  assign dn_abort_sym = dn_abort_reg;

  ////////////////////////////////////////////////////////////////////////////
  // client receive capture; check field stripped here

  logic [31:0] rx_capture_reg;
  logic rx_valid_reg;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      rx_capture_reg <= rscd_pkg::RX_CAPTURE_RST;
      rx_valid_reg <= 1'b0;
    end else begin
      rx_valid_reg <= up_valid && (up_target_id == node_id);
      if (up_valid && (up_target_id == node_id)) begin
        rx_capture_reg <= up_data[31:0];
      end
    end
  end

  assign rx_valid = rx_valid_reg;
  assign rx_symbol = rx_capture_reg;

  ////////////////////////////////////////////////////////////////////////////
  // first-abort log; system must reset the ring to rearm it

  logic logged_reg;
  logic [3:0] err_status_reg;
  logic [6:0] syndrome_reg;
  logic abort_reg;
  rscd_pkg::rscd_class_t class_reg;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      logged_reg <= 1'b0;
      err_status_reg <= rscd_pkg::ERR_RST;
      syndrome_reg <= rscd_pkg::SYN_RST;
      class_reg <= rscd_pkg::RSCD_NO_ERROR;
    end else if (abort_now && !logged_reg) begin
      logged_reg <= 1'b1;
      syndrome_reg <= syndrome_word;
      class_reg <= class_now;
      // a node seeing its own cause logs that cause; others log the symbol
      err_status_reg[rscd_pkg::ERR_CHECK_BIT] <= check_err;
      err_status_reg[rscd_pkg::ERR_ABORT_SYM_BIT] <=
        up_valid && up_is_abort_sym && !check_err && !abort_cause_local;
      err_status_reg[rscd_pkg::ERR_SEQ_BIT] <= up_valid && up_seq_error;
      err_status_reg[rscd_pkg::ERR_ADDR_BIT] <= addr_err;
    end
  end

  // pin stays up until ring reset; a returning abort symbol has no extra effect
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      abort_reg <= 1'b0;
    end else if (check_err || abort_cause_local) begin
      abort_reg <= 1'b1;
    end
  end

  assign abort_pin = abort_reg;
  assign err_class = class_reg;

  ////////////////////////////////////////////////////////////////////////////
  // nibble readout

  logic [31:0] diag_word;
  logic [3:0] nibble_reg;

  always_comb begin
    diag_word = 32'h0000_0000;
    diag_word[rscd_pkg::DIAG_NODE_ID_LSB +: 4] = 4'(node_id);
    diag_word[rscd_pkg::DIAG_MAX_ID_LSB +: 4] = 4'(max_id);
    diag_word[rscd_pkg::DIAG_ERR_LSB +: 4] = err_status_reg;
    diag_word[rscd_pkg::DIAG_SYN_MSB:rscd_pkg::DIAG_SYN_LSB] = syndrome_reg;
  end

  // registered so the client sees a stable nibble one cycle after select
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      nibble_reg <= 4'h0;
    end else if (nibble_select[rscd_pkg::SEL_DIAG_BIT]) begin
      nibble_reg <= diag_word[{nibble_select[2:0], 2'b00} +: 4];
    end else begin
      nibble_reg <= rx_capture_reg[{nibble_select[2:0], 2'b00} +: 4];
    end
  end

  assign nibble_out = nibble_reg;

  ////////////////////////////////////////////////////////////////////////////
  // assertions

  sequence s_first_abort;
    abort_now && !logged_reg;
  endsequence

  property p_log_syndrome;
    @(posedge clk_sys) disable iff (srst)
      s_first_abort |=> (syndrome_reg == $past(syndrome_word)) && logged_reg;
  endproperty
  a_log_syndrome: assert property (p_log_syndrome) else $error("syndrome not logged");

  property p_hold_log;
    @(posedge clk_sys) disable iff (srst)
      logged_reg |=> $stable(syndrome_reg) && $stable(err_status_reg);
  endproperty
  a_hold_log: assert property (p_hold_log) else $error("log changed after first abort");

  property p_dn_check;
    @(posedge clk_sys) disable iff (srst)
      dn_valid |-> (dn_check[6] == ((^dn_data) ^ (^dn_check[5:0])));
  endproperty
  a_dn_check: assert property (p_dn_check) else $error("downstream parity wrong");

  property p_check_abort_pin;
    @(posedge clk_sys) disable iff (srst)
      check_err |=> abort_pin ##1 abort_pin;
  endproperty
  a_check_abort_pin: assert property (p_check_abort_pin) else $error("abort pin missing");

  property p_no_sym_on_check;
    @(posedge clk_sys) disable iff (srst)
      check_err |=> !dn_abort_sym;
  endproperty
  a_no_sym_on_check: assert property (p_no_sym_on_check) else $error("abort symbol on check error");

  property p_addr_abort;
    @(posedge clk_sys) disable iff (srst)
      (addr_err && !check_err) |=> dn_abort_sym && abort_pin;
  endproperty
  a_addr_abort: assert property (p_addr_abort) else $error("address abort missing");

  property p_forward;
    @(posedge clk_sys) disable iff (srst)
      dn_valid_in |=> dn_valid && (dn_data == $past(dn_data_in));
  endproperty
  a_forward: assert property (p_forward) else $error("symbol dropped");

  property p_nibble_rx;
    @(posedge clk_sys) disable iff (srst)
      (!nibble_select[3] && $stable(rx_capture_reg)) |=>
        nibble_out == $past(rx_capture_reg[{nibble_select[2:0], 2'b00} +: 4]);
  endproperty
  a_nibble_rx: assert property (p_nibble_rx) else $error("wrong receive nibble");

  property p_zero_no_error;
    @(posedge clk_sys) disable iff (srst)
      (syndrome_word == 7'h00) |-> class_now == rscd_pkg::RSCD_NO_ERROR;
  endproperty
  a_zero_no_error: assert property (p_zero_no_error) else $error("zero syndrome misclassed");

  sequence s_local_cause;
    abort_cause_local && !check_err;
  endsequence

  property p_seq_abort;
    @(posedge clk_sys) disable iff (srst)
      s_local_cause |=> dn_abort_sym && abort_pin;
  endproperty
  a_seq_abort: assert property (p_seq_abort) else $error("local abort not signalled");

  property p_rx_capture;
    @(posedge clk_sys) disable iff (srst)
      (up_valid && (up_target_id == node_id)) |=> rx_valid && (rx_symbol == $past(up_data[31:0]));
  endproperty
  a_rx_capture: assert property (p_rx_capture) else $error("receive symbol not captured");

  property p_rx_hold;
    @(posedge clk_sys) disable iff (srst)
      !(up_valid && (up_target_id == node_id)) |=> $stable(rx_symbol);
  endproperty
  a_rx_hold: assert property (p_rx_hold) else $error("receive capture moved");

  property p_pin_sticky;
    @(posedge clk_sys) disable iff (srst)
      abort_pin |=> abort_pin;
  endproperty
  a_pin_sticky: assert property (p_pin_sticky) else $error("abort pin dropped");

  property p_diag_nibble;
    @(posedge clk_sys) disable iff (srst)
      nibble_select[rscd_pkg::SEL_DIAG_BIT] |=>
        nibble_out == $past(diag_word[{nibble_select[2:0], 2'b00} +: 4]);
  endproperty
  a_diag_nibble: assert property (p_diag_nibble) else $error("wrong diagnostics nibble");

  property p_check_pos;
    @(posedge clk_sys) disable iff (srst)
      (class_now == rscd_pkg::RSCD_SINGLE_CHECK) |-> $onehot(err_position);
  endproperty
  a_check_pos: assert property (p_check_pos) else $error("check bit position not single");

endmodule : rscd_ring_check

//--- bench/rscd_ring_partner.sv
// upstream neighbour node model sending check-protected symbols
module rscd_ring_partner (
  input wire logic clk_sys,
  output logic up_valid,
  output logic [34:0] up_data,
  output logic [6:0] up_check,
  output logic up_is_abort_sym,
  output logic up_seq_error,
  output logic [3:0] up_target_id
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    up_valid = 1'b0;
    up_data = 35'h0;
    up_check = 7'h00;
    up_is_abort_sym = 1'b0;
    up_seq_error = 1'b0;
    up_target_id = 4'h0;
  end
  function automatic logic [6:0] gen(input logic [34:0] d);
    logic [6:0] c;
    c = 7'h00;
    for (int n = 1; n <= 35; n++) begin
      if (d[n-1]) c[5:0] ^= n[5:0];
    end
    c[6] = ^d ^ ^c[5:0];
    return c;
  endfunction : gen
  // called at a falling edge; flips model line faults on purpose
  task automatic send(input logic [34:0] d, input logic [34:0] fd, input logic [6:0] fc,
                      input logic [3:0] t, input logic ab, input logic sq);
    up_valid = 1'b1;
    up_data = d ^ fd;
    up_check = gen(d) ^ fc;
    up_target_id = t;
    up_is_abort_sym = ab;
    up_seq_error = sq;
    @(negedge clk_sys);
    up_valid = 1'b0;
    // no pull on data, check and target lines, so released they show the inverse
    up_data = ~up_data;
    up_check = ~up_check;
    up_target_id = ~t;
    up_is_abort_sym = 1'b0;
    up_seq_error = 1'b0;
  endtask : send
endmodule : rscd_ring_partner

//--- bench/ring_symbol_check_diag_test.sv
// self-checking bench for the ring symbol check block
module ring_symbol_check_diag_test;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct packed {
    logic [34:0] fd;
    logic [6:0] fc;
    logic [3:0] tgt;
    logic ab;
    logic sq;
    logic [3:0] err;
    logic [6:0] syn;
    rscd_pkg::rscd_class_t cls;
    logic dab;
  } rscd_err_row_t;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic dn_valid_in = 1'b0;
  logic [34:0] dn_data_in = 35'h0;
  logic [3:0] nibble_select = 4'h0;
  logic [3:0] node_id = 4'h3;
  logic [3:0] max_id = 4'h9;
  logic up_valid, up_is_abort_sym, up_seq_error, dn_valid, dn_abort_sym, rx_valid, abort_pin;
  logic [34:0] up_data, dn_data;
  logic [6:0] up_check, dn_check;
  logic [3:0] up_target_id, nibble_out, nib;
  logic [31:0] rx_symbol;
  rscd_pkg::rscd_class_t err_class;
  int err_count = 0;
  int checks_done = 0;
  logic [34:0] good_rows [4] = '{35'h0_0000_0001, 35'h7_FFFF_FFFF, 35'h5_A5C3_0F96,
                                 35'h2_1234_5678};
  rscd_err_row_t err_rows [7] = '{
    '{35'h1_0000_0000, 7'h00, 4'h3, 1'b0, 1'b0, 4'h1, 7'h61, rscd_pkg::RSCD_SINGLE_DATA, 1'b0},
    '{35'h0, 7'h04, 4'h3, 1'b0, 1'b0, 4'h1, 7'h44, rscd_pkg::RSCD_SINGLE_CHECK, 1'b0},
    '{35'h0, 7'h40, 4'h3, 1'b0, 1'b0, 4'h1, 7'h40, rscd_pkg::RSCD_SINGLE_TOP, 1'b0},
    '{35'h3, 7'h00, 4'h3, 1'b0, 1'b0, 4'h1, 7'h03, rscd_pkg::RSCD_DOUBLE, 1'b0},
    '{35'h0, 7'h00, 4'h3, 1'b1, 1'b0, 4'h2, 7'h00, rscd_pkg::RSCD_NO_ERROR, 1'b0},
    '{35'h0, 7'h00, 4'h3, 1'b0, 1'b1, 4'h4, 7'h00, rscd_pkg::RSCD_NO_ERROR, 1'b1},
    '{35'h0, 7'h00, 4'hC, 1'b0, 1'b0, 4'h8, 7'h00, rscd_pkg::RSCD_NO_ERROR, 1'b1}};
  always #2.5 clk_sys = ~clk_sys;
  rscd_ring_partner i_rscd_ring_partner (.clk_sys(clk_sys), .up_valid(up_valid),
    .up_data(up_data), .up_check(up_check), .up_is_abort_sym(up_is_abort_sym),
    .up_seq_error(up_seq_error), .up_target_id(up_target_id));
  rscd_ring_check i_rscd_ring_check (.clk_sys(clk_sys), .srst(srst), .up_valid(up_valid),
    .up_data(up_data), .up_check(up_check), .up_is_abort_sym(up_is_abort_sym),
    .up_seq_error(up_seq_error), .up_target_id(up_target_id), .node_id(node_id),
    .max_id(max_id), .dn_valid_in(dn_valid_in), .dn_data_in(dn_data_in),
    .dn_valid(dn_valid), .dn_data(dn_data), .dn_check(dn_check),
    .dn_abort_sym(dn_abort_sym), .rx_valid(rx_valid), .rx_symbol(rx_symbol),
    .nibble_select(nibble_select), .nibble_out(nibble_out), .abort_pin(abort_pin),
    .err_class(err_class));
  ////////////////////////////////////////////////////////////
  task automatic cmp(input string nm, input logic [34:0] e, input logic [34:0] g);
    checks_done++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp
  task automatic cmp_cls(input rscd_pkg::rscd_class_t e, input rscd_pkg::rscd_class_t g);
    checks_done++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED err_class expected %0d seen %0d", e, g);
    end
  endtask : cmp_cls
  task automatic rd_nib(input logic [3:0] s);
    nibble_select = s;
    @(negedge clk_sys);
    nib = nibble_out;
  endtask : rd_nib
  task automatic ring_reset(input int n);
    srst = 1'b1;
    repeat (n) @(negedge clk_sys);
    srst = 1'b0;
  endtask : ring_reset
  task automatic print_verdict;
    $display("counts: checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : print_verdict
  ////////////////////////////////////////////////////////////
  initial begin
    #20000;
    err_count++;
    print_verdict();
  end
  initial begin
    @(negedge clk_sys);
    ring_reset(8);
    foreach (good_rows[i]) begin
      dn_valid_in = 1'b1;
      dn_data_in = good_rows[i];
      i_rscd_ring_partner.send(good_rows[i], 35'h0, 7'h00, node_id, 1'b0, 1'b0);
      dn_valid_in = 1'b0;
      cmp("rx_valid", 1'b1, rx_valid);
      cmp("rx_symbol", good_rows[i][31:0], rx_symbol);
      cmp("dn_valid", 1'b1, dn_valid);
      cmp("dn_data", good_rows[i], dn_data);
      cmp("dn_check", i_rscd_ring_partner.gen(good_rows[i]), dn_check);
      cmp("abort_pin", 1'b0, abort_pin);
      cmp_cls(rscd_pkg::RSCD_NO_ERROR, err_class);
      for (int k = 0; k < 8; k++) begin
        rd_nib(k[3:0]);
        cmp("nibble_out", good_rows[i][4*k+:4], nib);
      end
    end
    $display("test good symbols done");
    foreach (err_rows[i]) begin
      ring_reset(2);
      i_rscd_ring_partner.send(35'h0_1357_9BDF, err_rows[i].fd, err_rows[i].fc,
                               err_rows[i].tgt, err_rows[i].ab, err_rows[i].sq);
      // a foreign abort symbol alone is logged but leaves the pin low
      cmp("abort_pin", (err_rows[i].err & 4'hD) != 4'h0, abort_pin);
      cmp("dn_abort_sym", err_rows[i].dab, dn_abort_sym);
      cmp_cls(err_rows[i].cls, err_class);
      rd_nib(4'hA);
      cmp("err_status", err_rows[i].err, nib);
      rd_nib(4'hB);
      cmp("syndrome_lo", err_rows[i].syn[3:0], nib);
      rd_nib(4'hC);
      cmp("syndrome_hi", {1'b0, err_rows[i].syn[6:4]}, nib);
      i_rscd_ring_partner.send(35'h0, 35'h0, 7'h01, 4'hC, 1'b0, 1'b1);
      rd_nib(4'hA);
      cmp("err_status", err_rows[i].err, nib);
      cmp("abort_pin", 1'b1, abort_pin);
    end
    $display("test abort causes done");
    ring_reset(2);
    cmp("abort_pin", 1'b0, abort_pin);
    cmp("rx_symbol", 32'h0, rx_symbol);
    cmp_cls(rscd_pkg::RSCD_NO_ERROR, err_class);
    for (int k = 8; k < 16; k++) begin
      rd_nib(k[3:0]);
      cmp("diag_nibble", (k == 8) ? 4'h3 : ((k == 9) ? 4'h9 : 4'h0), nib);
    end
    $display("test reset clear done");
    i_rscd_ring_partner.send(35'h0_CAFE_0001, 35'h0, 7'h00, node_id, 1'b0, 1'b0);
    rd_nib(4'h0);
    cmp("nibble_out", 4'h1, nib);
    i_rscd_ring_partner.send(35'h0_0BAD_F00D, 35'h0, 7'h00, 4'h5, 1'b0, 1'b0);
    cmp("rx_valid", 1'b0, rx_valid);
    cmp("rx_symbol", 32'hCAFE_0001, rx_symbol);
    cmp("abort_pin", 1'b0, abort_pin);
    $display("test capture hold done");
    print_verdict();
  end
endmodule : ring_symbol_check_diag_test
